// [logic/mrm_pkg.sv]
package mrm_pkg;
   // Address map
   localparam int          ADDR_W          = 11;
   localparam int          DATA_W          = 16;
   localparam logic [10:0] ADDR_MAX        = 11'h7FF;
   localparam logic [8:0]  PORT_LO_OFS     = 9'h040;
   localparam logic [8:0]  PORT_HI_OFS     = 9'h1FF;
   localparam logic [8:0]  GLB_LO_END      = 9'h03F;
   localparam logic [10:0] GLB_END         = 11'h01F;
   localparam logic [10:0] SYS_LO          = 11'h030;
   localparam logic [10:0] SYS_HI          = 11'h03F;
   localparam logic [10:0] TEST_HI         = 11'h03F;
   localparam int          NUM_PORTS       = 4;
   // Global control register, its fields and reset value
   localparam logic [10:0] GCR_ADDR        = 11'h002;
   localparam int          GCR_RSTDP_BIT   = 1;
   localparam int          GCR_LCW_BIT     = 2;
   localparam int          GCR_UPD_BIT     = 3;
   localparam logic [15:0] GCR_RST_VAL     = 16'h0000;
   // Per-port relative offsets
   localparam logic [8:0]  P_CFG_OFS       = 9'h040;
   localparam logic [8:0]  P_LAT_OFS       = 9'h042;
   localparam logic [8:0]  P_IE_OFS        = 9'h044;
   localparam logic [8:0]  P_STAT_OFS      = 9'h046;
   localparam logic [8:0]  P_CNT_OFS       = 9'h048;
   localparam logic [8:0]  P_BLK_END       = 9'h05F;
   localparam logic [15:0] P_CFG_RST_VAL   = 16'h0000;
   localparam int          CNT_W           = 16;
   // Update handshake phases
   typedef enum logic [1:0] {
      MRM_UPD_IDLE = 2'b00,
      MRM_UPD_LOAD = 2'b01,
      MRM_UPD_ZERO = 2'b10
   } mrm_upd_e;
endpackage

// [logic/mrm_latch_bit.sv]
`timescale 1ns/1ps
// One latched status bit with re-arm and change option
module mrm_latch_bit
   import mrm_pkg::*;
(
   input  wire logic ref_clk_i,
   input  wire logic resetn_i,
   input  wire logic event_i,
   input  wire logic on_change_i,
   input  wire logic enable_i,
   input  wire logic clear_i,
   input  wire logic dp_clear_i,
   output logic      latched_o
);
   logic prev;
   logic latched;
   logic armed;
   logic next_prev;
   logic next_latched;
   logic next_armed;
   logic rise;
   logic fall;

   // Set beats clear so a same-cycle event is kept
   always_comb begin
      rise = event_i & ~prev;
      fall = ~event_i & prev;
      next_prev = event_i;
      next_latched = latched;
      next_armed = armed;
      if (clear_i) begin
         next_latched = 1'b0;
         next_armed = 1'b0; // [RQ9]
      end
      if (!event_i) begin
         next_armed = 1'b1;
      end
      if (enable_i && ((rise && (armed || !event_i || !prev)) || (on_change_i && fall))) begin
         next_latched = 1'b1; // [RQ9] [RQ10]
      end
      if (dp_clear_i) begin
         next_latched = 1'b0; // [RQ18]
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prev <= 1'b0;
         latched <= 1'b0;
         armed <= 1'b1;
      end else begin
         prev <= next_prev;
         latched <= next_latched;
         armed <= next_armed;
      end
   end

   assign latched_o = latched;

   chk_hold_no_event: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (!event_i && !clear_i && !dp_clear_i && latched) |=> latched)
      else $error("latched bit dropped without clear"); // [RQ9]
   chk_event_sets: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (enable_i && event_i && !prev && !dp_clear_i) |=> latched)
      else $error("rising event did not latch"); // [RQ9]
   chk_change_fall: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (enable_i && on_change_i && !event_i && prev && !dp_clear_i) |=> latched)
      else $error("falling event did not latch"); // [RQ10]
endmodule

// [logic/mrm_sat_counter.sv]
`timescale 1ns/1ps
// Saturating live counter with snapshot register
module mrm_sat_counter
   import mrm_pkg::*;
#(
   parameter int W = CNT_W
)(
   input  wire logic         ref_clk_i,
   input  wire logic         resetn_i,
   input  wire logic         event_i,
   input  wire logic         enable_i,
   input  wire logic         load_i,
   input  wire logic         dp_clear_i,
   output logic [W-1:0]      snap_o,
   output logic              live_zero_o
);
   localparam logic [W-1:0] MAXV = '1;
   logic [W-1:0] live;
   logic [W-1:0] snap;
   logic [W-1:0] next_live;
   logic [W-1:0] next_snap;
   logic         inc;
   logic         zero_force;
   logic         next_zero_force;

   // Load and zero in one step; an event that cycle starts the new count
   always_comb begin
      inc = event_i & enable_i;
      next_live = live;
      next_snap = snap;
      next_zero_force = load_i; // [RQ8]
      if (load_i) begin
         next_snap = live;
         next_live = inc ? W'(1) : '0; // [RQ8]
      end else if (inc && live != MAXV) begin
         next_live = live + W'(1); // [RQ7]
      end
      if (dp_clear_i) begin
         next_live = '0; // [RQ18]
         next_snap = '0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         live <= '0;
         snap <= '0;
         zero_force <= 1'b0;
      end else begin
         live <= next_live;
         snap <= next_snap;
         zero_force <= next_zero_force;
      end
   end

   assign snap_o = snap;
   // Zero indication held low the clock after a load
   assign live_zero_o = (live == '0) && !zero_force; // [RQ8]

   chk_saturate_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (live == MAXV && !load_i && !dp_clear_i) |=> live == MAXV)
      else $error("counter wrapped past maximum"); // [RQ7]
   chk_no_inc_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (!enable_i && !load_i && !dp_clear_i) |=> $stable(live))
      else $error("disabled counter moved"); // [RQ17]
endmodule

// [logic/mrm_regmap.sv]
`timescale 1ns/1ps
// Behaviour
// RQ1: Decode one 11-bit space 000 to 7FF
// RQ2: Unimplemented banks ignore writes, read zero
// RQ3: Global reset restores every register default
// RQ4: Host writes zeros to unassigned bits
// RQ5: Config writes ignored by operation during datapath reset
// RQ6: Host repeats rising-bit actions after datapath reset
// RQ7: Counters saturate at maximum
// RQ8: Update edge: done low, load, zero, done high
// RQ9: Latched bit sets once until event recurs
// RQ10: Change-latched bit sets on both edges
// RQ11: Config bit selects clear-on-read or clear-on-write
// RQ12: Read clears 16 bits or accessed byte
// RQ13: Write ones clear matching latched bits
// RQ14: Reserved config stays read-write, no effect
// RQ15: Reserved status zero, reserved latches not set
// RQ16: Reserved enables still raise interrupts
// RQ17: Reserved counters hold, update still works
// RQ18: Datapath reset after mode change clears latches, counters
// RQ19: Host clears counters by two updates
// RQ20: Ports at 040 to 1FF above each base
// RQ21: Absent ports discard writes, read zero
// RQ22: Ready strobe only for assigned locations
module mrm_regmap
   import mrm_pkg::*;
#(
   parameter int PORTS = NUM_PORTS,
   parameter int LAT_W = 8
)(
   input  wire logic                    ref_clk_i,
   input  wire logic                    resetn_i,
   input  wire logic                    datapath_reset_n_i,
   input  wire logic                    bus16_i,
   input  wire logic [mrm_pkg::ADDR_W-1:0] addr_i,
   input  wire logic                    rd_i,
   input  wire logic                    wr_i,
   input  wire logic [mrm_pkg::DATA_W-1:0] wdata_i,
   input  wire logic [NUM_PORTS*8-1:0]  port_event_i,
   input  wire logic [NUM_PORTS*8-1:0]  port_count_event_i,
   input  wire logic [NUM_PORTS-1:0]    port_mode_i,
   output logic [mrm_pkg::DATA_W-1:0]   rdata_o,
   output logic                         ready_o,
   output logic                         counter_update_done_o,
   output logic                         latched_clear_on_write_sel_o,
   output logic [NUM_PORTS*16-1:0]      port_cfg_o,
   output logic [NUM_PORTS-1:0]         port_irq_o
);
   // Port mode 1 makes lanes 7:4 reserved in this block
   localparam logic [7:0] ACTIVE_MODE1 = 8'h0F;

   logic [15:0]            gcr;
   logic [15:0]            next_gcr;
   logic [NUM_PORTS*16-1:0] cfg;
   logic [NUM_PORTS*16-1:0] next_cfg;
   logic [NUM_PORTS*16-1:0] cfg_eff;
   logic [NUM_PORTS*16-1:0] next_cfg_eff;
   logic [NUM_PORTS*8-1:0]  ie;
   logic [NUM_PORTS*8-1:0]  next_ie;
   logic [NUM_PORTS-1:0]    mode_q;
   logic [NUM_PORTS-1:0]    mode_chg;
   logic [NUM_PORTS-1:0]    next_mode_chg;
   logic                    upd_prev;
   mrm_upd_e                upd_st;
   mrm_upd_e                next_upd_st;
   logic                    next_upd_prev;
   logic                    upd_prev_rise;
   logic                    upd_load;
   logic [NUM_PORTS*8-1:0]  lat;
   logic [NUM_PORTS*8-1:0]  lat_clr;
   logic [NUM_PORTS*8-1:0]  lat_en;
   logic [NUM_PORTS*16-1:0] cnt_snap;
   logic [NUM_PORTS-1:0]    cnt_zero;
   logic [NUM_PORTS-1:0]    dp_clear;
   logic [1:0]              port_sel;
   logic [8:0]              rel;
   logic                    port_ok;
   logic                    in_glb;
   logic                    in_blk;
   logic [15:0]             rd_word;
   logic [15:0]             next_rdata;
   logic [15:0]             rdata;
   logic                    dp_active;

   // Address split: 2-bit port index and 9-bit offset
   assign port_sel = addr_i[10:9]; // [RQ1]
   assign rel = addr_i[8:0];
   assign port_ok = (int'(port_sel) < PORTS); // [RQ21]
   assign in_glb = (port_sel == 2'b00) && ((addr_i <= GLB_END) ||
                   (addr_i >= SYS_LO && addr_i <= SYS_HI));
   assign in_blk = port_ok && (rel >= PORT_LO_OFS) && (rel <= P_BLK_END); // [RQ20]
   assign dp_active = !datapath_reset_n_i;

   // Ready only for assigned locations, reserved words inside blocks included
   assign ready_o = (rd_i | wr_i) && (in_glb || in_blk); // [RQ22]

   // Read mux; unmapped or absent windows read zero
   always_comb begin
      rd_word = 16'h0000; // [RQ2] [RQ21]
      if (in_glb && addr_i == GCR_ADDR) begin
         rd_word = gcr;
      end else if (in_blk) begin
         unique case (rel)
            P_CFG_OFS:  rd_word = cfg[port_sel*16 +: 16]; // [RQ14]
            P_LAT_OFS:  rd_word = {8'h00, lat[port_sel*8 +: 8]};
            P_IE_OFS:   rd_word = {8'h00, ie[port_sel*8 +: 8]};
            P_STAT_OFS: rd_word = {8'h00, port_event_i[port_sel*8 +: 8] &
                                  (mode_q[port_sel] ? ACTIVE_MODE1 : 8'hFF)}; // [RQ15]
            P_CNT_OFS:  rd_word = cnt_snap[port_sel*16 +: 16];
            default:    rd_word = 16'h0000;
         endcase
      end
      next_rdata = rd_i ? rd_word : rdata;
   end

   // Config stores during datapath reset; operation sees a frozen copy
   always_comb begin
      next_gcr = gcr;
      next_cfg = cfg;
      next_ie = ie;
      next_cfg_eff = dp_active ? cfg_eff : cfg; // [RQ5]
      if (wr_i && in_glb && addr_i == GCR_ADDR) begin
         next_gcr = wdata_i;
      end
      if (wr_i && in_blk && rel == P_CFG_OFS) begin
         next_cfg[port_sel*16 +: 16] = wdata_i; // [RQ5] [RQ14]
      end
      if (wr_i && in_blk && rel == P_IE_OFS) begin
         next_ie[port_sel*8 +: 8] = wdata_i[7:0]; // [RQ16]
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gcr <= GCR_RST_VAL; // [RQ3]
         cfg <= {NUM_PORTS{P_CFG_RST_VAL}};
         cfg_eff <= {NUM_PORTS{P_CFG_RST_VAL}};
         ie <= '0;
         rdata <= 16'h0000;
      end else begin
         gcr <= next_gcr;
         cfg <= next_cfg;
         cfg_eff <= next_cfg_eff;
         ie <= next_ie;
         rdata <= next_rdata;
      end
   end

   // Update handshake; edge is ignored while datapath reset holds
   always_comb begin
      next_upd_prev = gcr[GCR_UPD_BIT];
      next_upd_st = upd_st;
      unique case (upd_st)
         MRM_UPD_IDLE: if (gcr[GCR_UPD_BIT] && !upd_prev && !dp_active) begin
            next_upd_st = MRM_UPD_LOAD; // [RQ8]
         end
         MRM_UPD_LOAD: next_upd_st = MRM_UPD_ZERO;
         MRM_UPD_ZERO: next_upd_st = MRM_UPD_IDLE;
         default:      next_upd_st = MRM_UPD_IDLE;
      endcase
   end
   assign upd_load = (upd_st == MRM_UPD_LOAD); // [RQ17]
   assign counter_update_done_o = (upd_st == MRM_UPD_IDLE) && !upd_prev_rise;
   assign upd_prev_rise = gcr[GCR_UPD_BIT] && !upd_prev && !dp_active;

   // Mode change memory feeds the automatic clear on datapath reset
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         next_mode_chg[p] = mode_chg[p];
         if (port_mode_i[p] != mode_q[p]) begin
            next_mode_chg[p] = 1'b1;
         end else if (dp_active) begin
            next_mode_chg[p] = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         upd_st <= MRM_UPD_IDLE;
         upd_prev <= 1'b0;
         mode_q <= '0;
         mode_chg <= '0;
      end else begin
         upd_st <= next_upd_st;
         upd_prev <= next_upd_prev;
         mode_q <= port_mode_i;
         mode_chg <= next_mode_chg;
      end
   end

   // Clear strobes: by read (word or byte) or by written ones
   always_comb begin
      lat_clr = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         dp_clear[p] = dp_active && (mode_chg[p] || port_mode_i[p] != mode_q[p]); // [RQ18]
         lat_en[p*8 +: 8] = mode_q[p] ? ACTIVE_MODE1 : 8'hFF; // [RQ15]
         if (in_blk && rel == P_LAT_OFS && int'(port_sel) == p) begin
            if (gcr[GCR_LCW_BIT] && wr_i) begin
               lat_clr[p*8 +: 8] = wdata_i[7:0]; // [RQ11] [RQ13]
            end else if (!gcr[GCR_LCW_BIT] && rd_i && (bus16_i || !addr_i[0])) begin
               lat_clr[p*8 +: 8] = 8'hFF; // [RQ11] [RQ12]
            end
         end
      end
   end

   // Latch cells, one per lane; counter cells, one per port
   for (genvar g = 0; g < NUM_PORTS*8; g++) begin : g_lat
      mrm_latch_bit u_lat (
         .ref_clk_i   (ref_clk_i),
         .resetn_i    (resetn_i),
         .event_i     (port_event_i[g]),
         .on_change_i (cfg_eff[(g/8)*16 + (g%8)]),
         .enable_i    (lat_en[g] && port_ok_g(g/8)),
         .clear_i     (lat_clr[g]),
         .dp_clear_i  (dp_clear[g/8]),
         .latched_o   (lat[g])
      );
   end
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_cnt
      mrm_sat_counter #(.W(CNT_W)) u_cnt (
         .ref_clk_i   (ref_clk_i),
         .resetn_i    (resetn_i),
         .event_i     (|port_count_event_i[p*8 +: 8]),
         .enable_i    (!mode_q[p] && !dp_active && port_ok_g(p)), // [RQ17]
         .load_i      (upd_load),
         .dp_clear_i  (dp_clear[p]),
         .snap_o      (cnt_snap[p*16 +: 16]),
         .live_zero_o (cnt_zero[p])
      );
      assign port_irq_o[p] = |(lat[p*8 +: 8] & ie[p*8 +: 8]); // [RQ16]
   end

   function automatic logic port_ok_g(input int idx);
      port_ok_g = (idx < PORTS);
   endfunction

   assign rdata_o = rdata;
   assign port_cfg_o = cfg_eff;
   assign latched_clear_on_write_sel_o = gcr[GCR_LCW_BIT];

   sequence s_upd_edge;
      gcr[GCR_UPD_BIT] && !upd_prev && !dp_active && upd_st == MRM_UPD_IDLE;
   endsequence
   sequence s_upd_steps;
      !counter_update_done_o ##1 (upd_load && !counter_update_done_o)
         ##1 !counter_update_done_o ##1 counter_update_done_o;
   endsequence
   chk_update_seq: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      s_upd_edge |-> s_upd_steps)
      else $error("update handshake out of order"); // [RQ8]
   chk_absent_ready: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (!port_ok && (rd_i || wr_i)) |-> !ready_o)
      else $error("ready for absent port"); // [RQ22]
   chk_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      (rd_i && !in_glb && !in_blk) |=> rdata_o == 16'h0000)
      else $error("unmapped read not zero"); // [RQ2]
   chk_cfg_frozen: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      dp_active |=> $stable(port_cfg_o))
      else $error("config acted during datapath reset"); // [RQ5]

   // Update handshake checks; zero phase must hide the zero indication
   sequence s_zero_phase;
      upd_st == MRM_UPD_ZERO;
   endsequence
   chk_zero_forced: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RQ8]
      s_zero_phase |-> cnt_zero == '0)
      else $error("zero indication not forced low");
   chk_done_busy: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RQ8]
      (upd_st != MRM_UPD_IDLE) |-> !counter_update_done_o)
      else $error("update done high while busy");
   chk_dp_no_update: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RQ5]
      (dp_active && upd_st == MRM_UPD_IDLE) |=> upd_st == MRM_UPD_IDLE)
      else $error("update started during datapath reset");

   // Decode checks: the unused 020 to 02F hole never answers
   chk_ready_unassigned: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RQ22]
      ((rd_i || wr_i) && addr_i[10:4] == 7'h02) |-> !ready_o)
      else $error("ready for unassigned address");
   chk_absent_no_write: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RQ21]
      (wr_i && !port_ok) |=> ($stable(cfg) && $stable(ie)))
      else $error("absent port write landed");

   // Status and clearing checks
   chk_stat_reserved: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RQ15]
      (rd_i && in_blk && rel == P_STAT_OFS && mode_q[port_sel]) |=> rdata_o[7:4] == 4'h0)
      else $error("reserved status bit read nonzero");
   chk_byte_read_keep: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RQ12]
      (rd_i && !bus16_i && addr_i[0] && !gcr[GCR_LCW_BIT]) |-> lat_clr == '0)
      else $error("upper byte read cleared latches");

   // Effective config follows the stored copy outside datapath reset
   chk_cfg_released: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RQ5]
      !dp_active |=> port_cfg_o == $past(cfg))
      else $error("effective config lags stored config");

   // Per-port: latches fall only when cleared; datapath clear empties all
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
      chk_lat_no_drop: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RQ13]
         (lat_clr[p*8 +: 8] == 8'h00 && !dp_clear[p])
         |=> (lat[p*8 +: 8] & $past(lat[p*8 +: 8])) == $past(lat[p*8 +: 8]))
         else $error("latched bit dropped without clear strobe");
      chk_dp_clears: assert property (@(posedge ref_clk_i) disable iff (!resetn_i) // [RQ18]
         dp_clear[p] |=> (lat[p*8 +: 8] == 8'h00 && cnt_snap[p*16 +: 16] == 16'h0000))
         else $error("datapath clear left state behind");
   end
endmodule

// [bench/mrm_host.sv]
`timescale 1ns/1ps
// Host processor model on the parallel register bus
module mrm_host
   import mrm_pkg::*;
(
   input  wire logic                       ref_clk_i,
   input  wire logic [mrm_pkg::DATA_W-1:0] rdata_i,
   input  wire logic                       ready_i,
   output logic [mrm_pkg::ADDR_W-1:0]      addr_o,
   output logic                            rd_o,
   output logic                            wr_o,
   output logic [mrm_pkg::DATA_W-1:0]      wdata_o
);
   import mrm_pkg::*;

   // Idle bus at time zero
   initial begin
      addr_o  = 11'h7FF;
      rd_o    = 1'b0;
      wr_o    = 1'b0;
      wdata_o = 16'h0000;
   end

   // One access: strobe for one cycle, ready at the taking edge, data 1 ns after that edge
   task automatic access(input logic is_wr, input logic [10:0] a, input logic [15:0] d,
                         output logic rdy, output logic [15:0] q);
      @(posedge ref_clk_i);
      addr_o  <= a;
      wdata_o <= d; // Callers pass zeros in unassigned positions
      rd_o    <= ~is_wr;
      wr_o    <= is_wr;
      @(posedge ref_clk_i);
      rdy = ready_i;
      rd_o    <= 1'b0;
      wr_o    <= 1'b0;
      // Released lines show the inverse, so stale values cannot pass
      addr_o  <= ~a;
      wdata_o <= ~d;
      #1;
      q = rdata_i;
   endtask
endmodule

// [bench/multiport_register_map_rules_bench.sv]
`timescale 1ns/1ps
// Self-checking bench: register accesses with expected values
module multiport_register_map_rules_bench;
   import mrm_pkg::*;
   // Three ports fitted, so the fourth window is absent
   localparam int NP = 3;

   logic        ref_clk;
   logic        resetn;
   logic        dp_rst_n;
   logic        bus16;
   logic [10:0] addr;
   logic        rd;
   logic        wr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [31:0] ev;
   logic [31:0] cev;
   logic [3:0]  mode;
   logic        ready;
   logic        done;
   logic        clr_sel;
   logic [63:0] cfg;
   logic [3:0]  irq;
   int          failures;
   int          checks;

   mrm_regmap #(.PORTS(NP), .LAT_W(8)) uut (
      .ref_clk_i                    (ref_clk),
      .resetn_i                     (resetn),
      .datapath_reset_n_i           (dp_rst_n),
      .bus16_i                      (bus16),
      .addr_i                       (addr),
      .rd_i                         (rd),
      .wr_i                         (wr),
      .wdata_i                      (wdata),
      .port_event_i                 (ev),
      .port_count_event_i           (cev),
      .port_mode_i                  (mode),
      .rdata_o                      (rdata),
      .ready_o                      (ready),
      .counter_update_done_o        (done),
      .latched_clear_on_write_sel_o (clr_sel),
      .port_cfg_o                   (cfg),
      .port_irq_o                   (irq)
   );

   mrm_host host (
      .ref_clk_i (ref_clk),
      .rdata_i   (rdata),
      .ready_i   (ready),
      .addr_o    (addr),
      .rd_o      (rd),
      .wr_o      (wr),
      .wdata_o   (wdata)
   );

   // Free-running clock, 5 ns period
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h", $time, msg, got);
      end
   endtask

   task automatic wr_reg(input logic [10:0] a, input logic [15:0] d, input logic er);
      logic        r;
      logic [15:0] q;
      host.access(1'b1, a, d, r, q);
      chk(r, er, "write ready");
   endtask

   task automatic rd_reg(input logic [10:0] a, input logic [15:0] e, input logic er,
                         input logic [15:0] m = 16'hFFFF);
      logic        r;
      logic [15:0] q;
      host.access(1'b0, a, 16'h0000, r, q);
      chk(r, er, "read ready");
      chk(q & m, e & m, "read data");
   endtask

   task automatic pulse(input int b);
      @(posedge ref_clk);
      ev[b] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      ev[b] <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask

   // Update request, done must drop then return within the walk
   task automatic upd(input logic [15:0] keep);
      int n;
      wr_reg(11'h002, keep | 16'h0008, 1'b1);
      for (n = 0; n < 4 && done !== 1'b0; n++) @(posedge ref_clk) #1;
      chk(done, 1'b0, "update done low");
      for (n = 0; n < 8 && done !== 1'b1; n++) @(posedge ref_clk) #1;
      chk(done, 1'b1, "update done high");
      wr_reg(11'h002, keep, 1'b1);
   endtask

   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Watchdog well beyond the saturation run
   initial begin
      #450000;
      failures++;
      finish_test();
   end

   // Main sequence
   initial begin
      failures = 0;
      checks   = 0;
      resetn   = 1'b0;
      dp_rst_n = 1'b1;
      bus16    = 1'b1;
      ev       = 32'h0;
      cev      = 32'h0;
      mode     = 4'h0;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk) #1;
      chk({done, clr_sel, irq}, 6'h20, "reset outputs");
      chk(cfg, 64'h0, "reset config");
      // Port windows, the absent one refuses
      for (int p = 0; p < 4; p++) begin
         wr_reg({p[1:0], 9'h040}, {8'h5A + p[7:0], 8'h00}, p < NP);
      end
      for (int p = 0; p < 4; p++) begin
         rd_reg({p[1:0], 9'h040}, (p < NP) ? {8'h5A + p[7:0], 8'h00} : 16'h0, p < NP);
         chk(cfg[p*16+:16], (p < NP) ? {8'h5A + p[7:0], 8'h00} : 16'h0, "cfg out");
      end
      rd_reg(11'h020, 16'h0, 1'b0);
      rd_reg(11'h7FF, 16'h0, 1'b0);
      rd_reg(11'h05E, 16'h0, 1'b1, 16'h0000);
      // Clear-on-read latch, no re-set while the event stays
      @(posedge ref_clk);
      ev[0] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rd_reg(11'h042, 16'h0001, 1'b1);
      rd_reg(11'h042, 16'h0000, 1'b1);
      ev[0] <= 1'b0;
      pulse(0);
      // Byte read of the upper half keeps the lower byte
      bus16 <= 1'b0;
      rd_reg(11'h043, 16'h0, 1'b1, 16'h0000);
      bus16 <= 1'b1;
      wr_reg(11'h044, 16'h0001, 1'b1);
      chk(irq[0], 1'b1, "irq raised");
      rd_reg(11'h042, 16'h0001, 1'b1);
      #1 chk(irq[0], 1'b0, "irq cleared");
      wr_reg(11'h044, 16'h0000, 1'b1);
      // Clear-on-write mode
      wr_reg(11'h002, 16'h0004, 1'b1);
      chk(clr_sel, 1'b1, "clear select");
      pulse(0);
      pulse(1);
      rd_reg(11'h042, 16'h0003, 1'b1);
      wr_reg(11'h042, 16'h0001, 1'b1);
      rd_reg(11'h042, 16'h0002, 1'b1);
      wr_reg(11'h042, 16'h00FF, 1'b1);
      // Change-latched lane sets on the falling edge too
      wr_reg(11'h040, 16'h5A01, 1'b1);
      ev[0] <= 1'b1;
      repeat (2) @(posedge ref_clk);
      wr_reg(11'h042, 16'h0001, 1'b1);
      ev[0] <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rd_reg(11'h042, 16'h0001, 1'b1);
      // Counter snapshot, clear by second update, saturation
      @(posedge ref_clk);
      cev[0] <= 1'b1;
      repeat (5) @(posedge ref_clk);
      cev[0] <= 1'b0;
      upd(16'h0004);
      rd_reg(11'h048, 16'h0005, 1'b1);
      upd(16'h0004);
      rd_reg(11'h048, 16'h0000, 1'b1);
      @(posedge ref_clk);
      cev[0] <= 1'b1;
      repeat (66000) @(posedge ref_clk);
      cev[0] <= 1'b0;
      upd(16'h0004);
      rd_reg(11'h048, 16'hFFFF, 1'b1);
      // Reserved lane after a mode change, then datapath reset
      pulse(8);
      @(posedge ref_clk);
      mode[1] <= 1'b1;
      pulse(12);
      ev[9]  <= 1'b1;
      ev[12] <= 1'b1;
      rd_reg(11'h246, 16'h0002, 1'b1);
      ev[9]  <= 1'b0;
      ev[12] <= 1'b0;
      rd_reg(11'h242, 16'h0003, 1'b1);
      @(posedge ref_clk);
      dp_rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rd_reg(11'h242, 16'h0000, 1'b1);
      wr_reg(11'h240, 16'h0033, 1'b1);
      rd_reg(11'h240, 16'h0033, 1'b1);
      chk(cfg[31:16], 16'h5B00, "frozen cfg");
      wr_reg(11'h002, 16'h000C, 1'b1);
      chk(done, 1'b1, "update ignored in datapath reset");
      @(posedge ref_clk);
      dp_rst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      chk(cfg[31:16], 16'h0033, "cfg after release");
      // The ignored update request is issued again after release
      wr_reg(11'h002, 16'h0004, 1'b1);
      upd(16'h0004);
      rd_reg(11'h248, 16'h0000, 1'b1);
      // Global reset in mid-run restores every default
      resetn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk) #1;
      chk({done, clr_sel}, 2'b10, "done and select after reset");
      chk(cfg, {4{P_CFG_RST_VAL}}, "config after reset");
      rd_reg(11'h002, GCR_RST_VAL, 1'b1);
      rd_reg(11'h042, 16'h0000, 1'b1);
      rd_reg(11'h240, P_CFG_RST_VAL, 1'b1);
      finish_test();
   end
endmodule
